// >>> osdpr_params.svh
// constants for the output stage and decimator power register pair
`ifndef OSDPR_PARAMS_SVH
`define OSDPR_PARAMS_SVH

// register offsets on the device register port
`define OSDPR_STAGE_ADDR     8'h43
`define OSDPR_DECIM_ADDR     8'h44

// reset values
`define OSDPR_STAGE_RST      8'h0F
`define OSDPR_DECIM_RST      8'h00

// output stage field positions
`define OSDPR_RMODE_BIT      5
`define OSDPR_LMODE_BIT      4
`define OSDPR_RPWR_HI        3
`define OSDPR_RPWR_LO        2
`define OSDPR_LPWR_HI        1
`define OSDPR_LPWR_LO        0

// decimator power field positions
`define OSDPR_DEC_HI         7
`define OSDPR_DEC_LO         4
`define OSDPR_FLT_HI         3
`define OSDPR_FLT_LO         0

// timing: headphone settle time before unmute, and the core clock rate
`define OSDPR_HP_SETTLE_MS   6
`define OSDPR_CLK_HZ         20000000
`define OSDPR_HP_SETTLE_CYC  ((`OSDPR_HP_SETTLE_MS * `OSDPR_CLK_HZ) / 1000)

`endif

// >>> osdpr_pkg.sv
// types shared by the output stage and decimator power register pair
package osdpr_pkg;

  // one access on the device register port
  typedef struct packed {
    logic       wr;     // write strobe, one cycle
    logic       rd;     // read strobe, one cycle
    logic [7:0] addr;   // register offset
    logic [7:0] wdata;  // write data
  } osdpr_req_t;

  // per channel power field encoding
  typedef enum logic [1:0] {
    OSDPR_PWR_BOTH = 2'b00,
    OSDPR_PWR_NEG  = 2'b01,
    OSDPR_PWR_POS  = 2'b10,
    OSDPR_PWR_DOWN = 2'b11
  } osdpr_pwr_t;

  // enables of one channel's pair of output drivers
  typedef struct packed {
    logic pos;  // positive driver enabled
    logic neg;  // negative driver enabled
  } osdpr_drv_t;

endpackage

// >>> osdpr_drv_decode.sv
// one output channel: driver enable decode and headphone settle timer
`timescale 1ns/1ps
`include "osdpr_params.svh"

module osdpr_drv_decode #(
  parameter int SETTLE_CYC = `OSDPR_HP_SETTLE_CYC
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // control from the output stage register
  input  wire logic                   mode_sel,
  input  wire osdpr_pkg::osdpr_pwr_t  power_field,
  // registered results
  output      osdpr_pkg::osdpr_drv_t  drv,
  output      logic                   hp_mode,
  output      logic                   settled
);
  import osdpr_pkg::*;

  localparam int CW = $clog2(SETTLE_CYC + 1);

  logic [CW-1:0] cnt_r;     // cycles spent powered in headphone mode
  logic          active;    // headphone mode with a driver on

  // decode ignores the mode bit on purpose: power acts in line and headphone mode alike
  always_ff @(posedge clk) begin
    if (rst) begin
      drv <= '0;
    end else begin
      drv.neg <= (power_field == OSDPR_PWR_BOTH) || (power_field == OSDPR_PWR_NEG);
      drv.pos <= (power_field == OSDPR_PWR_BOTH) || (power_field == OSDPR_PWR_POS);
    end
  end

  // mode select mirrored to the analogue side
  always_ff @(posedge clk) begin
    if (rst) begin
      hp_mode <= 1'b0;
    end else begin
      hp_mode <= mode_sel;
    end
  end

  assign active = hp_mode && (drv.pos || drv.neg);

  // settle timer: a hint for firmware, the device does not hold the mute itself
  always_ff @(posedge clk) begin
    if (rst || !active) begin
      cnt_r   <= '0;
      settled <= 1'b0;
    end else if (cnt_r == CW'(SETTLE_CYC - 1)) begin
      settled <= 1'b1;
    end else begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

endmodule

// >>> osdpr_regs.sv
// output stage control and decimator power registers with their decode
`timescale 1ns/1ps
`include "osdpr_params.svh"

// Operation
// RL1: bit 5 picks right line or headphone
// RL2: bit 4 picks left line or headphone
// RL3: right power field bits 3:2 decode
// RL4: left power field bits 1:0 decode
// RL5: power acts regardless of mode bit
// RL6: host waits 6 ms before unmuting headphone
// RL7: output stage register resets to 0x0F
// RL8: bits 7:4 power decimators 3 to 0
// RL9: bits 3:0 power ADC filters 3 to 0
// RL10: cleared bit stops that filter clock
// RL11: host sets filter and converter enable
// RL12: digital microphone needs filter bit only
// RL13: host powers filters of all used channels
module osdpr_regs #(
  parameter int SETTLE_CYC = `OSDPR_HP_SETTLE_CYC,
  parameter int NCH        = 4
) (
  // clock and reset
  clk,
  rst,
  // device register port
  reg_req,
  rd_data,
  rd_valid,
  // output mode selects
  right_headphone_mode_select,
  left_headphone_mode_select,
  // output driver enables
  right_positive_driver,
  right_negative_driver,
  left_positive_driver,
  left_negative_driver,
  // headphone settle status
  right_hp_settled,
  left_hp_settled,
  // filter and decimator clock enables
  filter_clk_en,
  decimator_clk_en
);
  import osdpr_pkg::*;

  input  wire logic                 clk;
  input  wire logic                 rst;
  input  wire osdpr_pkg::osdpr_req_t reg_req;
  output      logic [7:0]           rd_data;
  output      logic                 rd_valid;
  output      logic                 right_headphone_mode_select;
  output      logic                 left_headphone_mode_select;
  output      logic                 right_positive_driver;
  output      logic                 right_negative_driver;
  output      logic                 left_positive_driver;
  output      logic                 left_negative_driver;
  output      logic                 right_hp_settled;
  output      logic                 left_hp_settled;
  output      logic [NCH-1:0]       filter_clk_en;
  output      logic [NCH-1:0]       decimator_clk_en;

  logic [7:0]       stage_r;     // output stage control, reserved bits kept as written
  logic [7:0]       decim_r;     // decimator and filter power
  logic             stage_hit;   // access targets the output stage register
  logic             decim_hit;   // access targets the decimator power register
  logic [1:0]       ch_mode;     // index 0 left, 1 right
  osdpr_pwr_t       ch_pwr [2];  // per channel power field
  osdpr_drv_t       ch_drv [2];  // per channel driver enables
  logic [1:0]       ch_hp;       // per channel registered mode
  logic [1:0]       ch_set;      // per channel settle status

  // address decode
  always_comb begin
    stage_hit = 1'b0;
    decim_hit = 1'b0;
    if (reg_req.addr == `OSDPR_STAGE_ADDR) begin
      stage_hit = 1'b1;
    end else if (reg_req.addr == `OSDPR_DECIM_ADDR) begin
      decim_hit = 1'b1;
    end
  end

  // RL7 stage register write
  always_ff @(posedge clk) begin
    if (rst) begin
      stage_r <= `OSDPR_STAGE_RST;
    end else if (reg_req.wr && stage_hit) begin
      stage_r <= reg_req.wdata;
    end
  end

  // RL8 RL9 decimator power write
  always_ff @(posedge clk) begin
    if (rst) begin
      decim_r <= `OSDPR_DECIM_RST;
    end else if (reg_req.wr && decim_hit) begin
      decim_r <= reg_req.wdata;
    end
  end

  // read path: unmapped offsets answer zero so nothing floats on the port
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= reg_req.rd;
      if (!reg_req.rd) begin
        rd_data <= 8'h00;
      end else if (stage_hit) begin
        rd_data <= stage_r;
      end else if (decim_hit) begin
        rd_data <= decim_r;
      end else begin
        rd_data <= 8'h00;
      end
    end
  end

  // RL1 RL2 mode bits per channel
  assign ch_mode[0] = stage_r[`OSDPR_LMODE_BIT];
  assign ch_mode[1] = stage_r[`OSDPR_RMODE_BIT];
  // RL3 RL4 power fields per channel
  assign ch_pwr[0]  = osdpr_pwr_t'(stage_r[`OSDPR_LPWR_HI:`OSDPR_LPWR_LO]);
  assign ch_pwr[1]  = osdpr_pwr_t'(stage_r[`OSDPR_RPWR_HI:`OSDPR_RPWR_LO]);

  // RL5 independent channel decode
  for (genvar c = 0; c < 2; c++) begin : g_ch
    osdpr_drv_decode #(
      .SETTLE_CYC (SETTLE_CYC)
    ) u_dec (
      .clk         (clk),
      .rst         (rst),
      .mode_sel    (ch_mode[c]),
      .power_field (ch_pwr[c]),
      .drv         (ch_drv[c]),
      .hp_mode     (ch_hp[c]),
      .settled     (ch_set[c])
    );
  end

  // channel results are flops inside the decoders, wired straight out
  assign left_headphone_mode_select  = ch_hp[0];
  assign right_headphone_mode_select = ch_hp[1];
  assign left_positive_driver        = ch_drv[0].pos;
  assign left_negative_driver        = ch_drv[0].neg;
  assign right_positive_driver       = ch_drv[1].pos;
  assign right_negative_driver       = ch_drv[1].neg;
  // RL6 settle hint for the host
  assign left_hp_settled             = ch_set[0];
  assign right_hp_settled            = ch_set[1];

  // RL10 clock enables, registered so a glitch-free gate cell can use them
  always_ff @(posedge clk) begin
    if (rst) begin
      filter_clk_en    <= '0;
      decimator_clk_en <= '0;
    end else begin
      filter_clk_en    <= decim_r[`OSDPR_FLT_HI:`OSDPR_FLT_LO];
      decimator_clk_en <= decim_r[`OSDPR_DEC_HI:`OSDPR_DEC_LO];
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_stage_wr;
    reg_req.wr && stage_hit;
  endsequence

  sequence s_decim_wr;
    reg_req.wr && decim_hit;
  endsequence

  property p_stage_reset;
    $fell(rst) |-> (stage_r == `OSDPR_STAGE_RST) && (decim_r == `OSDPR_DECIM_RST);
  endproperty
  a_stage_reset: assert property (p_stage_reset) else $error("bad reset value"); // RL7

  property p_stage_write;
    s_stage_wr |=> ##1 (right_headphone_mode_select == $past(reg_req.wdata[5], 2));
  endproperty
  a_stage_write: assert property (p_stage_write) else $error("right mode not taken"); // RL1

  property p_left_mode;
    s_stage_wr |=> ##1 (left_headphone_mode_select == $past(reg_req.wdata[4], 2));
  endproperty
  a_left_mode: assert property (p_left_mode) else $error("left mode not taken"); // RL2

  property p_right_neg_only;
    stage_r[3:2] == 2'b01 |=> right_negative_driver && !right_positive_driver;
  endproperty
  a_right_neg_only: assert property (p_right_neg_only) else $error("right decode wrong"); // RL3

  property p_left_down;
    stage_r[1:0] == 2'b11 |=> !left_positive_driver && !left_negative_driver;
  endproperty
  a_left_down: assert property (p_left_down) else $error("left not powered down"); // RL4

  property p_left_both;
    stage_r[1:0] == 2'b00 && stage_r[4] |=> left_positive_driver && left_negative_driver;
  endproperty
  a_left_both: assert property (p_left_both) else $error("headphone mode blocks drivers"); // RL5

  property p_filter_clk;
    s_decim_wr |=> ##1 (filter_clk_en == $past(reg_req.wdata[3:0], 2));
  endproperty
  a_filter_clk: assert property (p_filter_clk) else $error("filter clock enable wrong"); // RL9

  property p_decim_clk;
    s_decim_wr |=> ##1 (decimator_clk_en == $past(reg_req.wdata[7:4], 2));
  endproperty
  a_decim_clk: assert property (p_decim_clk) else $error("decimator clock enable wrong"); // RL8

  property p_clk_stop;
    !decim_r[0] [*2] |-> !filter_clk_en[0];
  endproperty
  a_clk_stop: assert property (p_clk_stop) else $error("filter clock not stopped"); // RL10

  property p_read;
    reg_req.rd && stage_hit |=> rd_valid && (rd_data == $past(stage_r));
  endproperty
  a_read: assert property (p_read) else $error("stage readback wrong"); // RL7

endmodule

// >>> osdpr_regs_tb.sv
// self-checking bench for the output stage and decimator power registers
`timescale 1ns/1ps
`include "osdpr_params.svh"

module osdpr_regs_tb;
  import osdpr_pkg::*;

  logic             clk;      // 20 MHz core clock
  logic             rst;      // synchronous reset, active high
  osdpr_req_t       req;      // register port request
  logic [7:0]       rd_data;  // read answer
  logic             rd_valid; // read answer strobe
  logic             rhp;      // right headphone mode
  logic             lhp;      // left headphone mode
  logic             rp;       // right positive driver
  logic             rn;       // right negative driver
  logic             lp;       // left positive driver
  logic             ln;       // left negative driver
  logic             rset;     // right settled hint
  logic             lset;     // left settled hint
  logic [3:0]       flt;      // filter clock enables
  logic [3:0]       dec;      // decimator clock enables
  int               n_errors; // mismatches seen
  int               checks;   // comparisons made
  int               cyc;      // watchdog count
  logic [7:0]       v;        // read value
  logic [7:0]       d;        // write value

  // short settle count keeps the run brief
  osdpr_regs #(.SETTLE_CYC(8), .NCH(4)) dut (
    .clk(clk), .rst(rst), .reg_req(req), .rd_data(rd_data), .rd_valid(rd_valid),
    .right_headphone_mode_select(rhp), .left_headphone_mode_select(lhp),
    .right_positive_driver(rp), .right_negative_driver(rn),
    .left_positive_driver(lp), .left_negative_driver(ln),
    .right_hp_settled(rset), .left_hp_settled(lset),
    .filter_clk_en(flt), .decimator_clk_en(dec));

  // free running clock, 50 ns period
  always #25 clk = ~clk;

  // watchdog: a hang counts as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      n_errors = n_errors + 1;
      close_out();
    end
  end

  // compare one value and count it
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one write strobe, raised and dropped at falling edges
  task automatic wr(input logic [7:0] a, input logic [7:0] wd);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: wd};
    @(negedge clk);
    req.wr = 1'b0;
  endtask

  // one read strobe; answer stands in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    req.rd = 1'b0;
    chk("rd_valid", 8'h01, {7'h00, rd_valid});
    q = rd_data;
  endtask

  // expected {pos,neg} enables for a power field code
  function automatic logic [1:0] drv_of(input logic [1:0] c);
    return {c == 2'b00 || c == 2'b10, c == 2'b00 || c == 2'b01};
  endfunction

  // verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    req = '0;
    n_errors = 0;
    checks = 0;
    cyc = 0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    // reset values and idle outputs
    rd(`OSDPR_STAGE_ADDR, v);
    chk("stage reset", 8'h0F, v);
    rd(`OSDPR_DECIM_ADDR, v);
    chk("decim reset", 8'h00, v);
    chk("outputs reset", 8'h00, {rhp, lhp, rp, rn, lp, ln, 2'b00});
    chk("enables reset", 8'h00, {dec, flt});
    $display("test reset done");
    // every power code under both modes, channels told apart
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 4; c++) begin
        d = {m[0], m[0], m[0], ~m[0], c[1:0], ~c[1:0]};
        wr(`OSDPR_STAGE_ADDR, d);
        @(negedge clk);
        chk("modes", {6'h00, m[0], ~m[0]}, {6'h00, rhp, lhp});
        chk("drivers", {4'h0, drv_of(c[1:0]), drv_of(~c[1:0])}, {4'h0, rp, rn, lp, ln});
        rd(`OSDPR_STAGE_ADDR, v);
        chk("stage readback", d, v);
      end
    end
    $display("test stage decode done");
    // decimator and filter enables, each bit alone and mixed
    foreach (d[i]) begin
      wr(`OSDPR_DECIM_ADDR, 8'h01 << i);
      @(negedge clk);
      chk("clock enables", 8'h01 << i, {dec, flt});
    end
    // host powers every filter and decimator of the channels in use
    wr(`OSDPR_DECIM_ADDR, 8'hFF);
    @(negedge clk);
    chk("all enables", 8'hFF, {dec, flt});
    wr(`OSDPR_DECIM_ADDR, 8'hA5);
    @(negedge clk);
    chk("clock enables", 8'hA5, {dec, flt});
    rd(`OSDPR_DECIM_ADDR, v);
    chk("decim readback", 8'hA5, v);
    $display("test decimator done");
    // unmapped offset: write ignored, read gives zero
    wr(8'h45, 8'hFF);
    rd(8'h45, v);
    chk("unmapped read", 8'h00, v);
    rd(`OSDPR_DECIM_ADDR, v);
    chk("decim untouched", 8'hA5, v);
    $display("test unmapped done");
    // headphone settle hint: low early, high after the count
    wr(`OSDPR_STAGE_ADDR, 8'h30);
    @(negedge clk);
    chk("settled early", 8'h00, {6'h00, rset, lset});
    repeat (7) @(negedge clk);
    chk("settled edge", 8'h00, {6'h00, rset, lset});
    @(negedge clk);
    chk("settled late", 8'h03, {6'h00, rset, lset});
    wr(`OSDPR_STAGE_ADDR, 8'h3F);
    repeat (2) @(negedge clk);
    chk("settled drop", 8'h00, {6'h00, rset, lset});
    $display("test settle done");
    // second reset in mid-run restores both registers
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    rd(`OSDPR_STAGE_ADDR, v);
    chk("stage rereset", 8'h0F, v);
    rd(`OSDPR_DECIM_ADDR, v);
    chk("decim rereset", 8'h00, v);
    chk("enables rereset", 8'h00, {dec, flt});
    chk("outputs rereset", 8'h00, {rhp, lhp, rp, rn, lp, ln, 2'b00});
    $display("test second reset done");
    close_out();
  end
endmodule
